// file: rtl/rsad_decoder.sv
`timescale 1ns/1ns
`include "rsad_regs.svh"
// How it works
// - data addresses 28 bits, fetch 24 bits
// - global pointer fixed, writes ignored
// - thread pointer fixed at peripheral base
// - fetch from flash, data from flash, psram, scratch ram or peripherals
// - one shared memory access at once
// - fetches only execute from flash
// - loads anywhere, stores anywhere but flash
// - flash and two psram windows decoded
// - 32-byte scratch ram, window wraps
// - gpio, serial, spi windows decoded
// - pwm, debug, timer, game windows decoded
module rsad_decoder #(
  parameter int IRAM_BYTES = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fetch_req_i,
  input wire logic [23:0] fetch_addr_i,
  input wire logic data_req_i,
  input wire logic data_we_i,
  input wire logic [27:0] data_addr_i,
  input wire logic [3:0] data_be_i,
  input wire logic [31:0] data_wdata_i,
  output logic fetch_done_o,
  output logic fetch_fault_o,
  output logic data_done_o,
  output logic data_fault_o,
  output logic [31:0] resp_rdata_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [23:0] mem_addr_o,
  output logic [3:0] mem_be_o,
  output logic [31:0] mem_wdata_o,
  output logic flash_cs_n_o,
  output logic rama_cs_n_o,
  output logic ramb_cs_n_o,
  input wire logic mem_done_i,
  input wire logic [31:0] mem_rdata_i,
  output logic [6:0] periph_sel_o,
  output logic periph_we_o,
  output logic [5:0] periph_addr_o,
  output logic [31:0] periph_wdata_o,
  input wire logic [31:0] periph_rdata_i,
  input wire logic rf_we_i,
  input wire logic [3:0] rf_waddr_i,
  output logic rf_we_o,
  output logic [3:0] rf_waddr_o,
  output logic [31:0] gp_o,
  output logic [31:0] tp_o
);
  import rsad_pkg::*;

  localparam int IRAM_WORDS = IRAM_BYTES / 4;
  localparam int IW = $clog2(IRAM_WORDS);

  function automatic logic in_win(input logic [27:0] a,
                                  input logic [27:0] lo,
                                  input logic [27:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // byte offset inside an external device window
  function automatic logic [23:0] dev_offset(input logic [27:0] a,
                                             input logic [27:0] lo);
    logic [27:0] d;
    d = a - lo;
    return d[23:0];
  endfunction

  function automatic rsad_target_t decode(input logic [27:0] a);
    rsad_target_t t;
    t = RSAD_T_NONE;
    if (in_win(a, `RSAD_FLASH_LO, `RSAD_FLASH_HI)) t = RSAD_T_FLASH;
    if (in_win(a, `RSAD_RAMA_LO, `RSAD_RAMA_HI)) t = RSAD_T_RAMA;
    if (in_win(a, `RSAD_RAMB_LO, `RSAD_RAMB_HI)) t = RSAD_T_RAMB;
    if (in_win(a, `RSAD_IRAM_LO, `RSAD_IRAM_HI)) t = RSAD_T_IRAM;
    if (in_win(a, `RSAD_GPIO_LO, `RSAD_GPIO_HI)) t = RSAD_T_GPIO;
    if (in_win(a, `RSAD_UART_LO, `RSAD_UART_HI)) t = RSAD_T_UART;
    if (in_win(a, `RSAD_SPI_LO, `RSAD_SPI_HI)) t = RSAD_T_SPI;
    if (in_win(a, `RSAD_PWM_LO, `RSAD_PWM_HI)) t = RSAD_T_PWM;
    if (in_win(a, `RSAD_DBG_LO, `RSAD_DBG_HI)) t = RSAD_T_DBG;
    if (in_win(a, `RSAD_TIME_LO, `RSAD_TIME_HI)) t = RSAD_T_TIME;
    if (in_win(a, `RSAD_GAME_LO, `RSAD_GAME_HI)) t = RSAD_T_GAME;
    return t;
  endfunction

  function automatic logic [6:0] periph_onehot(input rsad_target_t t);
    logic [6:0] s;
    s = 7'h00;
    unique case (t)
      RSAD_T_GPIO: s = 7'h01;
      RSAD_T_UART: s = 7'h02;
      RSAD_T_SPI: s = 7'h04;
      RSAD_T_PWM: s = 7'h08;
      RSAD_T_DBG: s = 7'h10;
      RSAD_T_TIME: s = 7'h20;
      RSAD_T_GAME: s = 7'h40;
      default: s = 7'h00;
    endcase
    return s;
  endfunction

  rsad_state_t st_r, st_nxt;
  logic owner_data_r, owner_data_nxt;
  logic fetch_done_r, fetch_done_nxt;
  logic data_done_r, data_done_nxt;
  logic fault_r, fault_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic mem_req_r, mem_req_nxt;
  logic mem_we_r, mem_we_nxt;
  logic [23:0] mem_addr_r, mem_addr_nxt;
  logic [3:0] mem_be_r, mem_be_nxt;
  logic [31:0] mem_wdata_r, mem_wdata_nxt;
  logic [2:0] cs_n_r, cs_n_nxt;
  logic [6:0] psel_r, psel_nxt;
  logic pwe_r, pwe_nxt;
  logic [5:0] paddr_r, paddr_nxt;
  logic [31:0] pwdata_r, pwdata_nxt;
  logic [31:0] iram_r [IRAM_WORDS];
  logic [31:0] iram_nxt [IRAM_WORDS];
  logic rf_we_r, rf_we_nxt;
  logic [3:0] rf_waddr_r;
  logic [31:0] gp_r, tp_r;
  logic fetch_fault_r, data_fault_r;

  logic grant_data;
  logic take;
  logic [27:0] req_addr;
  logic req_we;
  rsad_target_t tgt;
  logic [IW-1:0] iram_idx;

  rsad_arb u_arb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .want_fetch_i(fetch_req_i),
    .want_data_i(data_req_i),
    .take_i(take),
    .grant_data_o(grant_data)
  );

  always_comb begin
    // fetch address zero-extended, upper bits never seen
    req_addr = grant_data ? data_addr_i : {4'h0, fetch_addr_i};
    req_we = grant_data && data_we_i;
    tgt = decode(req_addr);
    // window wraps onto the scratch words
    iram_idx = req_addr[IW+1:2];
    take = 1'b0;
    st_nxt = st_r;
    owner_data_nxt = owner_data_r;
    fault_nxt = fault_r;
    rdata_nxt = rdata_r;
    mem_req_nxt = mem_req_r;
    mem_we_nxt = mem_we_r;
    mem_addr_nxt = mem_addr_r;
    mem_be_nxt = mem_be_r;
    mem_wdata_nxt = mem_wdata_r;
    cs_n_nxt = cs_n_r;
    psel_nxt = 7'h00;
    pwe_nxt = 1'b0;
    paddr_nxt = paddr_r;
    pwdata_nxt = pwdata_r;
    iram_nxt = iram_r;
    unique case (st_r)
      RSAD_S_IDLE: begin
        if (fetch_req_i || data_req_i) begin
          take = 1'b1;
          owner_data_nxt = grant_data;
          fault_nxt = 1'b0;
          rdata_nxt = 32'h00000000;
          st_nxt = RSAD_S_DONE;
          mem_we_nxt = req_we;
          mem_addr_nxt = req_addr[23:0];
          mem_be_nxt = data_be_i;
          mem_wdata_nxt = data_wdata_i;
          if (!grant_data && tgt != RSAD_T_FLASH) begin
            fault_nxt = 1'b1;
          end else begin
            unique case (tgt)
              RSAD_T_FLASH: begin
                if (req_we) begin
                  fault_nxt = 1'b1;
                end else begin
                  mem_req_nxt = 1'b1;
                  cs_n_nxt = 3'b110;
                  st_nxt = RSAD_S_MEM;
                end
              end
              RSAD_T_RAMA: begin
                mem_req_nxt = 1'b1;
                mem_addr_nxt = dev_offset(req_addr, `RSAD_RAMA_LO);
                cs_n_nxt = 3'b101;
                st_nxt = RSAD_S_MEM;
              end
              RSAD_T_RAMB: begin
                mem_req_nxt = 1'b1;
                mem_addr_nxt = dev_offset(req_addr, `RSAD_RAMB_LO);
                cs_n_nxt = 3'b011;
                st_nxt = RSAD_S_MEM;
              end
              RSAD_T_IRAM: begin
                rdata_nxt = iram_r[iram_idx];
                if (req_we) begin
                  for (int b = 0; b < 4; b++) begin
                    if (data_be_i[b]) begin
                      iram_nxt[iram_idx][8*b +: 8] = data_wdata_i[8*b +: 8];
                    end
                  end
                end
              end
              RSAD_T_NONE: begin
                rdata_nxt = 32'h00000000;
              end
              default: begin
                psel_nxt = periph_onehot(tgt);
                pwe_nxt = req_we;
                paddr_nxt = req_addr[5:0];
                pwdata_nxt = data_wdata_i;
                st_nxt = RSAD_S_PERIPH;
              end
            endcase
          end
        end
      end
      RSAD_S_MEM: begin
        if (mem_done_i) begin
          if (!mem_we_r) begin
            rdata_nxt = mem_rdata_i;
          end
          mem_req_nxt = 1'b0;
          cs_n_nxt = 3'b111;
          st_nxt = RSAD_S_DONE;
        end
      end
      RSAD_S_PERIPH: begin
        if (!pwe_r) begin
          rdata_nxt = periph_rdata_i;
        end
        st_nxt = RSAD_S_DONE;
      end
      RSAD_S_DONE: begin
        st_nxt = RSAD_S_IDLE;
      end
    endcase
    fetch_done_nxt = (st_nxt == RSAD_S_DONE) && (st_r != RSAD_S_DONE)
                     && !owner_data_nxt;
    data_done_nxt = (st_nxt == RSAD_S_DONE) && (st_r != RSAD_S_DONE)
                    && owner_data_nxt;
    rf_we_nxt = rf_we_i && rf_waddr_i != `RSAD_GP_INDEX
                && rf_waddr_i != `RSAD_TP_INDEX;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= RSAD_S_IDLE;
      owner_data_r <= 1'b0;
      fetch_done_r <= 1'b0;
      data_done_r <= 1'b0;
      fetch_fault_r <= 1'b0;
      data_fault_r <= 1'b0;
      fault_r <= 1'b0;
      rdata_r <= 32'h00000000;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= 24'h000000;
      mem_be_r <= 4'h0;
      mem_wdata_r <= 32'h00000000;
      cs_n_r <= 3'b111;
      psel_r <= 7'h00;
      pwe_r <= 1'b0;
      paddr_r <= 6'h00;
      pwdata_r <= 32'h00000000;
      for (int i = 0; i < IRAM_WORDS; i++) begin
        iram_r[i] <= 32'h00000000;
      end
      rf_we_r <= 1'b0;
      rf_waddr_r <= 4'h0;
      gp_r <= `RSAD_GP_VALUE;
      tp_r <= `RSAD_TP_VALUE;
    end else begin
      st_r <= st_nxt;
      owner_data_r <= owner_data_nxt;
      fetch_done_r <= fetch_done_nxt;
      data_done_r <= data_done_nxt;
      fetch_fault_r <= fetch_done_nxt && fault_nxt;
      data_fault_r <= data_done_nxt && fault_nxt;
      fault_r <= fault_nxt;
      rdata_r <= rdata_nxt;
      mem_req_r <= mem_req_nxt;
      mem_we_r <= mem_we_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_be_r <= mem_be_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      cs_n_r <= cs_n_nxt;
      psel_r <= psel_nxt;
      pwe_r <= pwe_nxt;
      paddr_r <= paddr_nxt;
      pwdata_r <= pwdata_nxt;
      iram_r <= iram_nxt;
      rf_we_r <= rf_we_nxt;
      rf_waddr_r <= rf_waddr_i;
      gp_r <= `RSAD_GP_VALUE;
      tp_r <= `RSAD_TP_VALUE;
    end
  end

  assign fetch_done_o = fetch_done_r;
  assign data_done_o = data_done_r;
  assign fetch_fault_o = fetch_fault_r;
  assign data_fault_o = data_fault_r;
  assign resp_rdata_o = rdata_r;
  assign mem_req_o = mem_req_r;
  assign mem_we_o = mem_we_r;
  assign mem_addr_o = mem_addr_r;
  assign mem_be_o = mem_be_r;
  assign mem_wdata_o = mem_wdata_r;
  assign flash_cs_n_o = cs_n_r[0];
  assign rama_cs_n_o = cs_n_r[1];
  assign ramb_cs_n_o = cs_n_r[2];
  assign periph_sel_o = psel_r;
  assign periph_we_o = pwe_r;
  assign periph_addr_o = paddr_r;
  assign periph_wdata_o = pwdata_r;
  assign rf_we_o = rf_we_r;
  assign rf_waddr_o = rf_waddr_r;
  assign gp_o = gp_r;
  assign tp_o = tp_r;
endmodule

// file: rtl/rsad_regs.svh
`ifndef RSAD_REGS_SVH
`define RSAD_REGS_SVH

// external memory windows
`define RSAD_FLASH_LO 28'h0000000
`define RSAD_FLASH_HI 28'h00FFFFF
`define RSAD_RAMA_LO 28'h1000000
`define RSAD_RAMA_HI 28'h17FFFFF
`define RSAD_RAMB_LO 28'h1800000
`define RSAD_RAMB_HI 28'h1FFFFFF

// on-chip scratch ram window
`define RSAD_IRAM_LO 28'h7FFFF00
`define RSAD_IRAM_HI 28'h7FFFFFF

// peripheral windows
`define RSAD_GPIO_LO 28'h8000000
`define RSAD_GPIO_HI 28'h8000007
`define RSAD_UART_LO 28'h8000010
`define RSAD_UART_HI 28'h800001F
`define RSAD_SPI_LO 28'h8000020
`define RSAD_SPI_HI 28'h8000027
`define RSAD_PWM_LO 28'h8000028
`define RSAD_PWM_HI 28'h800002B
`define RSAD_DBG_LO 28'h8000030
`define RSAD_DBG_HI 28'h8000033
`define RSAD_TIME_LO 28'h8000034
`define RSAD_TIME_HI 28'h800003B
`define RSAD_GAME_LO 28'h8000040
`define RSAD_GAME_HI 28'h8000047

// fixed pointer registers
`define RSAD_GP_VALUE 32'h01000400
`define RSAD_TP_VALUE 32'h08000000
`define RSAD_GP_INDEX 4'h3
`define RSAD_TP_INDEX 4'h4

`endif

// file: rtl/rsad_pkg.sv
package rsad_pkg;

  typedef enum logic [3:0] {
    RSAD_T_NONE,
    RSAD_T_FLASH,
    RSAD_T_RAMA,
    RSAD_T_RAMB,
    RSAD_T_IRAM,
    RSAD_T_GPIO,
    RSAD_T_UART,
    RSAD_T_SPI,
    RSAD_T_PWM,
    RSAD_T_DBG,
    RSAD_T_TIME,
    RSAD_T_GAME
  } rsad_target_t;

  typedef enum logic [1:0] {
    RSAD_S_IDLE,
    RSAD_S_MEM,
    RSAD_S_PERIPH,
    RSAD_S_DONE
  } rsad_state_t;

endpackage

// file: rtl/rsad_arb.sv
`timescale 1ns/1ns
// picks between fetch and data; alternates when both wait
module rsad_arb (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic want_fetch_i,
  input wire logic want_data_i,
  input wire logic take_i,
  output logic grant_data_o
);
  logic last_data_r;
  logic last_data_nxt;

  always_comb begin
    if (want_fetch_i && want_data_i) begin
      grant_data_o = !last_data_r;
    end else begin
      grant_data_o = want_data_i;
    end
    last_data_nxt = take_i ? grant_data_o : last_data_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_data_r <= 1'b0;
    end else begin
      last_data_r <= last_data_nxt;
    end
  end
endmodule

// file: verification/rsad_decoder_asserts.sv
`timescale 1ns/1ns
module rsad_decoder_asserts #(
  parameter int IRAM_BYTES = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic flash_cs_n_o,
  input wire logic rama_cs_n_o,
  input wire logic ramb_cs_n_o,
  input wire logic mem_done_i,
  input wire logic fetch_done_o,
  input wire logic data_done_o,
  input wire logic [6:0] periph_sel_o,
  input wire logic [5:0] periph_addr_o,
  input wire logic [27:0] data_addr_i,
  input wire logic rf_we_i,
  input wire logic [3:0] rf_waddr_i,
  input wire logic rf_we_o,
  input wire logic [3:0] rf_waddr_o,
  input wire logic [31:0] gp_o,
  input wire logic [31:0] tp_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence mem_finish;
    mem_req_o && mem_done_i;
  endsequence
  sequence core_done;
    fetch_done_o || data_done_o;
  endsequence
  sequence periph_strobe;
    periph_sel_o != 7'h00;
  endsequence
  cs_exclusive_a:
    assert property (mem_req_o |->
      $onehot(~{flash_cs_n_o, rama_cs_n_o, ramb_cs_n_o}))
    else $error("chip selects not exclusive");
  cs_idle_a:
    assert property (!mem_req_o |->
      (flash_cs_n_o && rama_cs_n_o && ramb_cs_n_o))
    else $error("chip select low while idle");
  mem_finish_a:
    assert property (mem_finish |=> !mem_req_o ##0 core_done)
    else $error("memory access did not complete");
  flash_readonly_a:
    assert property (mem_req_o && !flash_cs_n_o |-> !mem_we_o)
    else $error("write reached flash");
  periph_done_a:
    assert property (periph_strobe |-> $onehot(periph_sel_o)
      ##1 (data_done_o && periph_sel_o == 7'h00))
    else $error("peripheral strobe wrong");
  periph_addr_a:
    assert property (periph_strobe |-> periph_addr_o == data_addr_i[5:0])
    else $error("peripheral offset wrong");
  ptr_fixed_a:
    assert property (gp_o == 32'h01000400 && tp_o == 32'h08000000)
    else $error("pointer value changed");
  ptr_guard_a:
    assert property (rf_we_i && (rf_waddr_i == 4'h3 || rf_waddr_i == 4'h4)
      |=> !rf_we_o)
    else $error("pointer write not blocked");
  rf_pass_a:
    assert property (rf_we_i && rf_waddr_i != 4'h3 && rf_waddr_i != 4'h4
      |=> rf_we_o && rf_waddr_o == $past(rf_waddr_i))
    else $error("register write lost");
endmodule

// file: verification/rsad_qspi_model.sv
`timescale 1ns/1ns
module rsad_qspi_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mem_req_i,
  input wire logic [23:0] mem_addr_i,
  input wire logic [2:0] cs_n_i,
  input wire logic [1:0] delay_i,
  output logic mem_done_o,
  output logic [31:0] mem_rdata_o
);
  logic [1:0] cnt;
  logic [7:0] tag;
  // top byte names the selected chip
  always_comb begin
    case (cs_n_i)
      3'b110: tag = 8'hF1;
      3'b101: tag = 8'hA1;
      3'b011: tag = 8'hB1;
      default: tag = 8'hEE;
    endcase
  end
  // data lines toggle whenever no word is being handed over
  always @(posedge clk_i) begin
    mem_rdata_o <= rst_i ? 32'h00000000 : ~mem_rdata_o;
    if (rst_i || !mem_req_i || mem_done_o) begin
      cnt <= 2'h0;
      mem_done_o <= 1'b0;
    end else if (cnt == delay_i) begin
      mem_done_o <= 1'b1;
      mem_rdata_o <= {tag, mem_addr_i};
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fetch_req_i, data_req_i, data_we_i, mem_done_i, rf_we_i;
  logic fetch_done_o, fetch_fault_o, data_done_o, data_fault_o, mem_req_o;
  logic mem_we_o, flash_cs_n_o, rama_cs_n_o, ramb_cs_n_o, periph_we_o;
  logic rf_we_o;
  logic [23:0] fetch_addr_i, mem_addr_o;
  logic [27:0] data_addr_i;
  logic [3:0] data_be_i, rf_waddr_i, mem_be_o, rf_waddr_o;
  logic [31:0] data_wdata_i, mem_rdata_i, periph_rdata_i, resp_rdata_o;
  logic [31:0] mem_wdata_o, periph_wdata_o, gp_o, tp_o;
  logic [6:0] periph_sel_o;
  logic [5:0] periph_addr_o;
  logic [1:0] dly;
  logic [7:0] saw;
  logic [33:0] me;
  logic [33:0] exp_q[$];
  logic [27:0] mt[6] = '{28'h0000000, 28'h00FFFFC, 28'h1000000,
    28'h17FFFFC, 28'h1800000, 28'h1FFFFFC};
  logic [27:0] pt[14] = '{28'h8000000, 28'h8000007, 28'h8000010,
    28'h800001F, 28'h8000020, 28'h8000027, 28'h8000028, 28'h800002B,
    28'h8000030, 28'h8000033, 28'h8000034, 28'h800003B, 28'h8000040,
    28'h8000047};
  logic [27:0] ut[8] = '{28'h800002C, 28'h800003C, 28'h8000048,
    28'h2000000, 28'h0100000, 28'h7FFFEFC, 28'h8000008, 28'hFFFFFFC};
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int i, k;

  always #25 clk_i = ~clk_i;

  rsad_decoder #(.IRAM_BYTES(32)) rsad_decoder_i (.*);
  rsad_qspi_model rsad_qspi_model_i (.clk_i(clk_i), .rst_i(rst_i),
    .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .delay_i(dly),
    .cs_n_i({ramb_cs_n_o, rama_cs_n_o, flash_cs_n_o}),
    .mem_done_o(mem_done_i), .mem_rdata_o(mem_rdata_i));

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task print_verdict;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wait_done(input logic f);
    for (k = 0; k < 40 && (f ? fetch_done_o : data_done_o) !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
  endtask

  task automatic access(input logic f, we, input logic [27:0] a,
      input logic [33:0] e, input logic [7:0] se);
    @(negedge clk_i);
    saw = 8'h00;
    dly = $urandom % 4;
    exp_q.push_back(e);
    {fetch_req_i, data_req_i, data_we_i} = {f, !f, we};
    fetch_addr_i = a[23:0];
    data_addr_i = a;
    wait_done(f);
    check({25'h0, saw}, {25'h0, se});
    @(negedge clk_i);
    {fetch_req_i, data_req_i} = 2'b00;
  endtask

  always @(posedge clk_i) saw <= saw | {mem_req_o, periph_sel_o};

  // oldest note against each completion; bit 33 skips the data word
  always @(negedge clk_i) begin
    if (fetch_done_o === 1'b1 || data_done_o === 1'b1) begin
      me = exp_q.pop_front();
      check({fetch_fault_o | data_fault_o,
        me[33] ? me[31:0] : resp_rdata_o}, me[32:0]);
    end
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    {fetch_req_i, data_req_i, data_we_i, rf_we_i, dly} = '0;
    {fetch_addr_i, data_addr_i, data_be_i, rf_waddr_i} = '0;
    {data_wdata_i, periph_rdata_i} = '0;
    k = $urandom(80756);
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    // both wait at once: data first, then fetch
    @(negedge clk_i);
    exp_q.push_back({2'b00, 32'hA1000008});
    exp_q.push_back({2'b00, 32'hF1000100});
    {fetch_req_i, data_req_i, data_we_i} = 3'b110;
    data_addr_i = 28'h1000008;
    fetch_addr_i = 24'h000100;
    wait_done(1'b0);
    @(negedge clk_i);
    data_req_i = 1'b0;
    wait_done(1'b1);
    @(negedge clk_i);
    fetch_req_i = 1'b0;
    for (i = 0; i < 6; i++) begin
      access(0, 0, mt[i], {2'b00, mt[i][24] ? (mt[i][23] ? 8'hB1 : 8'hA1)
        : 8'hF1, mt[i][23:0] - {mt[i][24] & mt[i][23], 23'h0}}, 8'h80);
    end
    access(1, 0, 28'h00FFFFC, {2'b00, 32'hF10FFFFC}, 8'h80);
    access(1, 0, 28'h0100000, {2'b01, 32'h0}, 8'h00);
    data_wdata_i = $urandom;
    access(0, 1, 28'h1800010, {2'b10, 32'h0}, 8'h80);
    access(0, 1, 28'h0000010, {2'b11, 32'h0}, 8'h00);
    for (i = 0; i < 14; i++) begin
      periph_rdata_i = $urandom;
      access(0, i[0], pt[i], {i[0], 1'b0, periph_rdata_i},
        8'h01 << (i / 2));
    end
    for (i = 0; i < 8; i++) begin
      access(0, i[0], ut[i], {i[0], 33'h0}, 8'h00);
    end
    data_be_i = 4'h3;
    access(0, 1, 28'h7FFFF04, {2'b10, 32'h0}, 8'h00);
    data_be_i = 4'hF;
    access(0, 0, 28'h7FFFFE4, {18'h0, data_wdata_i[15:0]}, 8'h00);
    access(0, 0, 28'h7FFFF00, 34'h0, 8'h00);
    for (i = 0; i < 16; i++) begin
      @(negedge clk_i);
      {rf_we_i, rf_waddr_i} = {1'b1, i[3:0]};
      @(negedge clk_i);
      check({rf_we_o, rf_waddr_o}, {i != 3 && i != 4, i[3:0]});
    end
    rf_we_i = 1'b0;
    check({1'b0, gp_o}, 33'h001000400);
    check({1'b0, tp_o}, 33'h008000000);
    repeat (4) @(negedge clk_i);
    if (exp_q.size() != 0) n_fail++;
    print_verdict();
  end
endmodule

bind rsad_decoder rsad_decoder_asserts #(.IRAM_BYTES(IRAM_BYTES))
  rsad_decoder_asserts_i (.*);
